//--- rtl/apsel_params.svh
// Purpose: Offsets, fields, reset values and select codes of the aux pin selector
// Assumes: Included by bare name; definitions only
// Notes:   Select codes double as bit indices of the source vector
//
// Summary of operation
// - Pin B selector is a 5-bit read-write field, bits 4-0, register 0x55.
// - Pin B shows the selected source only while its direction is output.
// - Code 0 drives pin B low; code 1 routes the DSP pin B output.
// - Code 2 drives pin B from level register bit 5.
// - Code 3 is both-channel auto-mute; codes 4 and 5 left and right auto-mute.
// - Code 6 is clock invalid: clock error OR changing OR missing.
// - Code 7 routes the serial audio data output stream.
// - Codes 8 and 9 give left and right analog mute, both active low.
// - Code 10 gives PLL lock; code 11 gives the charge pump clock.
// - Codes 12 and 13 give left and right short detection despite reserved listing.
// - Codes 14 and 15 give soft-mute input comparator undervoltage flags, high and low.
// - Codes 16 and 17 give PLL clock and oscillator clock divided by four.
// - Codes 18 and 19 give left and right impedance-sense flags.
// - Code 20 gives the undervoltage protection flag, low on core supply drop.
// - Code 21 gives the flag held while offset self-calibration runs.
// - Codes 22, 23, 24 give clock error, clock changing, clock missing.
// - Code 25 gives the clock-halt detection flag.
// - Code 26 gives the DSP boot-done flag.
// - Code 27 gives the active-low charge pump voltage valid flag.
// - Level bit 5 sets pin B low or high only under code 2.
// - Level bit 4 sets the mute pin under code 2 of its selector.
// - Level bit 3 sets pin A under code 2 of its selector.
// - Pin A has its own 5-bit selector, same codes, only in output mode.
`ifndef APSEL_PARAMS_SVH
`define APSEL_PARAMS_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define APSEL_OFS_PIN_A_SEL 8'h53
`define APSEL_OFS_SPARE     8'h54
`define APSEL_OFS_PIN_B_SEL 8'h55
`define APSEL_OFS_LEVELS    8'h56
`define APSEL_RST_BYTE      8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define APSEL_SEL_MSB       4
`define APSEL_SEL_LSB       0
`define APSEL_LVL_B_BIT     5
`define APSEL_LVL_MUTE_BIT  4
`define APSEL_LVL_A_BIT     3

// ----------------------------------------
// Select codes
// ----------------------------------------
`define APSEL_C_LOW      5'h00
`define APSEL_C_DSP      5'h01
`define APSEL_C_SOFT     5'h02
`define APSEL_C_AM_BOTH  5'h03
`define APSEL_C_AM_L     5'h04
`define APSEL_C_AM_R     5'h05
`define APSEL_C_CLK_INV  5'h06
`define APSEL_C_SDATA    5'h07
`define APSEL_C_AMUTE_L  5'h08
`define APSEL_C_AMUTE_R  5'h09
`define APSEL_C_PLL_LOCK 5'h0a
`define APSEL_C_CP_CLK   5'h0b
`define APSEL_C_SHORT_L  5'h0c
`define APSEL_C_SHORT_R  5'h0d
`define APSEL_C_UV_HI    5'h0e
`define APSEL_C_UV_LO    5'h0f
`define APSEL_C_PLL_D4   5'h10
`define APSEL_C_OSC_D4   5'h11
`define APSEL_C_IMP_L    5'h12
`define APSEL_C_IMP_R    5'h13
`define APSEL_C_UVP      5'h14
`define APSEL_C_OFS_CAL  5'h15
`define APSEL_C_CLK_ERR  5'h16
`define APSEL_C_CLK_CHG  5'h17
`define APSEL_C_CLK_MISS 5'h18
`define APSEL_C_CLK_HALT 5'h19
`define APSEL_C_BOOT     5'h1a
`define APSEL_C_CP_OK_N  5'h1b
`define APSEL_NUM_SRC    28

`endif

//--- rtl/apsel_pkg.sv
// Purpose: Types shared by the aux pin selector files
// Assumes: Nothing
// Notes:   Constants live in apsel_params.svh
package apsel_pkg;
  typedef logic [4:0] apsel_sel_t;
  typedef logic [7:0] apsel_byte_t;
  typedef logic [1:0] apsel_div_t;
endpackage

//--- rtl/apsel_src_mux.sv
// Purpose: One pin's source multiplexer with a registered output
// Assumes: All source bits are already in the sys_clk domain
// Notes:   Codes at or above NUM_SRC give a constant low
module apsel_src_mux
  import apsel_pkg::*;
#(
  parameter int NUM_SRC = 28
)
(
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire apsel_sel_t         sel,
  input  wire logic [NUM_SRC-1:0] src,
  output logic                    level_q
);

  if (NUM_SRC < 3 || NUM_SRC > 32)
  begin : g_chk
    $error("NUM_SRC must lie between 3 and 32");
  end

  function automatic logic pick(apsel_sel_t s, logic [NUM_SRC-1:0] v);
    logic r;
    r = 1'b0;
    if (32'(s) < NUM_SRC)
    begin
      r = v[s];
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      level_q <= 1'b0;
    end
    else
    begin
      level_q <= pick(sel, src);
    end
  end

endmodule // apsel_src_mux

//--- rtl/apsel_top.sv
// Purpose: Aux pin A, aux pin B and mute pin source selection with soft levels
// Assumes: Register port driven by the control-port core on sys_clk
// Notes:   Analog flags and raw clocks are synchronised; raw clocks must be
//          slower than sys_clk/2 for the divide-by-four to count every edge
`include "apsel_params.svh"

module apsel_top
  import apsel_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire apsel_byte_t reg_addr,
  input  wire apsel_byte_t reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output apsel_byte_t      reg_rdata_q,
  // Direction controls, set elsewhere
  input  wire logic        pin_a_dir_out,
  input  wire logic        pin_b_dir_out,
  // Same-domain sources
  input  wire logic        dsp_pin_a_out,
  input  wire logic        dsp_pin_b_out,
  input  wire logic        dsp_mute_out,
  input  wire logic        auto_mute_l,
  input  wire logic        auto_mute_r,
  input  wire logic        clk_error,
  input  wire logic        clk_changing,
  input  wire logic        clk_missing,
  input  wire logic        clk_halt,
  input  wire logic        serial_audio_out,
  input  wire logic        analog_mute_l_n,
  input  wire logic        analog_mute_r_n,
  input  wire logic        pll_lock,
  input  wire logic        offset_cal_busy,
  input  wire logic        dsp_boot_done,
  // Asynchronous sources
  input  wire logic        cp_clk,
  input  wire logic        pll_clk,
  input  wire logic        osc_clk,
  input  wire logic        short_l,
  input  wire logic        short_r,
  input  wire logic        soft_mute_input_uv_hi,
  input  wire logic        soft_mute_input_uv_lo,
  input  wire logic        imp_sense_l,
  input  wire logic        imp_sense_r,
  input  wire logic        undervoltage_protect,
  input  wire logic        cp_valid_n,
  // Pins
  output logic             aux_pin_a_o,
  output logic             aux_pin_a_oe,
  output logic             aux_pin_b_o,
  output logic             aux_pin_b_oe,
  output logic             mute_pin_o
);

  localparam int NSRC = `APSEL_NUM_SRC;
  localparam int NASY = 11;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  apsel_byte_t pin_a_source_select_q;
  apsel_byte_t spare_slot_after_pin_a_select_q;
  apsel_byte_t pin_b_source_select_q;
  apsel_byte_t soft_output_levels_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pin_a_source_select_q           <= `APSEL_RST_BYTE;
      spare_slot_after_pin_a_select_q <= `APSEL_RST_BYTE;
      pin_b_source_select_q           <= `APSEL_RST_BYTE;
      soft_output_levels_q            <= `APSEL_RST_BYTE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `APSEL_OFS_PIN_A_SEL: pin_a_source_select_q           <= reg_wdata;
        `APSEL_OFS_SPARE:     spare_slot_after_pin_a_select_q <= reg_wdata;
        `APSEL_OFS_PIN_B_SEL: pin_b_source_select_q           <= reg_wdata;
        `APSEL_OFS_LEVELS:    soft_output_levels_q            <= reg_wdata;
        default:              ;
      endcase
    end
  end

  // Other addresses belong to other blocks and read as zero here
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata_q <= `APSEL_RST_BYTE;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `APSEL_OFS_PIN_A_SEL: reg_rdata_q <= pin_a_source_select_q;
        `APSEL_OFS_SPARE:     reg_rdata_q <= spare_slot_after_pin_a_select_q;
        `APSEL_OFS_PIN_B_SEL: reg_rdata_q <= pin_b_source_select_q;
        `APSEL_OFS_LEVELS:    reg_rdata_q <= soft_output_levels_q;
        default:              reg_rdata_q <= `APSEL_RST_BYTE;
      endcase
    end
  end

  apsel_sel_t a_sel;
  apsel_sel_t b_sel;
  apsel_sel_t m_sel;
  assign a_sel = pin_a_source_select_q[`APSEL_SEL_MSB:`APSEL_SEL_LSB];
  assign b_sel = pin_b_source_select_q[`APSEL_SEL_MSB:`APSEL_SEL_LSB];
  // Mute selector sits in the spare slot, as the mute level bit implies
  assign m_sel = spare_slot_after_pin_a_select_q[`APSEL_SEL_MSB:`APSEL_SEL_LSB];

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [NASY-1:0] asy_raw;
  logic [NASY-1:0] asy_s1_q;
  logic [NASY-1:0] asy_s2_q;
  assign asy_raw = {cp_valid_n, undervoltage_protect, imp_sense_r,
                    imp_sense_l, soft_mute_input_uv_lo,
                    soft_mute_input_uv_hi, short_r, short_l,
                    osc_clk, pll_clk, cp_clk};

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      asy_s1_q <= '0;
      asy_s2_q <= '0;
    end
    else
    begin
      asy_s1_q <= asy_raw;
      asy_s2_q <= asy_s1_q;
    end
  end

  // ----------------------------------------
  // Divide by four
  // ----------------------------------------
  function automatic apsel_div_t div_next(apsel_div_t c, logic prev, logic cur);
    apsel_div_t r;
    r = c;
    if (cur && !prev)
    begin
      r = c + 2'h1;
    end
    return r;
  endfunction

  logic       pll_prev_q;
  logic       osc_prev_q;
  apsel_div_t pll_div_q;
  apsel_div_t osc_div_q;

  // count rising edges, MSB toggles at a quarter rate
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pll_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
      pll_div_q  <= 2'h0;
      osc_div_q  <= 2'h0;
    end
    else
    begin
      pll_prev_q <= asy_s2_q[1];
      osc_prev_q <= asy_s2_q[2];
      pll_div_q  <= div_next(pll_div_q, pll_prev_q, asy_s2_q[1]);
      osc_div_q  <= div_next(osc_div_q, osc_prev_q, asy_s2_q[2]);
    end
  end

  // ----------------------------------------
  // Source vector, shared by all pins
  // ----------------------------------------
  logic [NSRC-1:0] src_com;
  always_comb
  begin
    src_com = '0;
    src_com[`APSEL_C_LOW]      = 1'b0;
    src_com[`APSEL_C_AM_BOTH]  = auto_mute_l & auto_mute_r;
    src_com[`APSEL_C_AM_L]     = auto_mute_l;
    src_com[`APSEL_C_AM_R]     = auto_mute_r;
    src_com[`APSEL_C_CLK_INV]  = clk_error | clk_changing | clk_missing;
    src_com[`APSEL_C_SDATA]    = serial_audio_out;
    src_com[`APSEL_C_AMUTE_L]  = analog_mute_l_n;
    src_com[`APSEL_C_AMUTE_R]  = analog_mute_r_n;
    src_com[`APSEL_C_PLL_LOCK] = pll_lock;
    src_com[`APSEL_C_CP_CLK]   = asy_s2_q[0];
    // short detection on both listed codes
    src_com[`APSEL_C_SHORT_L]  = asy_s2_q[3];
    src_com[`APSEL_C_SHORT_R]  = asy_s2_q[4];
    src_com[`APSEL_C_UV_HI]    = asy_s2_q[5];
    src_com[`APSEL_C_UV_LO]    = asy_s2_q[6];
    src_com[`APSEL_C_PLL_D4]   = pll_div_q[1];
    src_com[`APSEL_C_OSC_D4]   = osc_div_q[1];
    src_com[`APSEL_C_IMP_L]    = asy_s2_q[7];
    src_com[`APSEL_C_IMP_R]    = asy_s2_q[8];
    src_com[`APSEL_C_UVP]      = asy_s2_q[9];
    src_com[`APSEL_C_OFS_CAL]  = offset_cal_busy;
    src_com[`APSEL_C_CLK_ERR]  = clk_error;
    src_com[`APSEL_C_CLK_CHG]  = clk_changing;
    src_com[`APSEL_C_CLK_MISS] = clk_missing;
    src_com[`APSEL_C_CLK_HALT] = clk_halt;
    src_com[`APSEL_C_BOOT]     = dsp_boot_done;
    src_com[`APSEL_C_CP_OK_N]  = asy_s2_q[10];
  end

  // Per-pin DSP and soft-level entries
  logic [NSRC-1:0] src_a;
  logic [NSRC-1:0] src_b;
  logic [NSRC-1:0] src_m;
  always_comb
  begin
    src_a = src_com;
    src_b = src_com;
    src_m = src_com;
    src_a[`APSEL_C_DSP]  = dsp_pin_a_out;
    src_b[`APSEL_C_DSP]  = dsp_pin_b_out;
    src_m[`APSEL_C_DSP]  = dsp_mute_out;
    src_b[`APSEL_C_SOFT] = soft_output_levels_q[`APSEL_LVL_B_BIT];
    src_a[`APSEL_C_SOFT] = soft_output_levels_q[`APSEL_LVL_A_BIT];
    src_m[`APSEL_C_SOFT] = soft_output_levels_q[`APSEL_LVL_MUTE_BIT];
  end

  // ----------------------------------------
  // Pin multiplexers
  // ----------------------------------------
  // pin A selector
  apsel_src_mux #(.NUM_SRC(NSRC)) u_mux_a
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sel     (a_sel),
    .src     (src_a),
    .level_q (aux_pin_a_o)
  );

  apsel_src_mux #(.NUM_SRC(NSRC)) u_mux_b
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sel     (b_sel),
    .src     (src_b),
    .level_q (aux_pin_b_o)
  );

  apsel_src_mux #(.NUM_SRC(NSRC)) u_mux_m
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sel     (m_sel),
    .src     (src_m),
    .level_q (mute_pin_o)
  );

  assign aux_pin_b_oe = pin_b_dir_out;
  assign aux_pin_a_oe = pin_a_dir_out;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sel_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr && reg_addr == `APSEL_OFS_PIN_B_SEL
    |=> b_sel == $past(reg_wdata[`APSEL_SEL_MSB:`APSEL_SEL_LSB]))
    else $error("pin B selector not written");

  b_oe_dir_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pin_b_dir_out |-> !aux_pin_b_oe)
    else $error("pin B driven while input");

  b_low_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    b_sel == `APSEL_C_LOW [*2] |-> !aux_pin_b_o)
    else $error("pin B not low under code 0");

  b_dsp_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    b_sel == `APSEL_C_DSP |=> aux_pin_b_o == $past(dsp_pin_b_out))
    else $error("pin B not following DSP");

  b_soft_lvl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    b_sel == `APSEL_C_SOFT
    |=> aux_pin_b_o == $past(soft_output_levels_q[`APSEL_LVL_B_BIT]))
    else $error("pin B not at soft level");

  b_mute_and_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    b_sel == `APSEL_C_AM_BOTH
    |=> aux_pin_b_o == ($past(auto_mute_l) && $past(auto_mute_r)))
    else $error("combined auto-mute wrong");

  b_clk_inv_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    b_sel == `APSEL_C_CLK_INV
    |=> aux_pin_b_o == $past(clk_error | clk_changing | clk_missing))
    else $error("clock invalid flag wrong");

  b_unused_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    b_sel > `APSEL_C_CP_OK_N |=> !aux_pin_b_o)
    else $error("unused code not low");

  a_soft_lvl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    a_sel == `APSEL_C_SOFT
    |=> aux_pin_a_o == $past(soft_output_levels_q[`APSEL_LVL_A_BIT]))
    else $error("pin A not at soft level");

  m_soft_lvl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    m_sel == `APSEL_C_SOFT
    |=> mute_pin_o == $past(soft_output_levels_q[`APSEL_LVL_MUTE_BIT]))
    else $error("mute pin not at soft level");

  reset_zero_a: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> b_sel == 5'h00 && !aux_pin_b_o
    && soft_output_levels_q == 8'h00)
    else $error("not zero after reset");

  soft_b_cov: cover property (@(posedge sys_clk) disable iff (sys_rst)
    b_sel == `APSEL_C_SOFT && aux_pin_b_oe && aux_pin_b_o);
  div_pll_cov: cover property (@(posedge sys_clk) disable iff (sys_rst)
    b_sel == `APSEL_C_PLL_D4 && $rose(aux_pin_b_o));
  mute_dsp_cov: cover property (@(posedge sys_clk) disable iff (sys_rst)
    m_sel == `APSEL_C_DSP && mute_pin_o);

endmodule // apsel_top

//--- tb/apsel_board_model.sv
// Purpose: Board side of aux pins A and B, with pull-up resistors
// Assumes: Pin levels and enables come straight from apsel_top
// Notes:   A released pin reads high, so a stale low cannot pass as driven
module apsel_board_model
(
  input  wire logic pin_a_o,
  input  wire logic pin_a_oe,
  input  wire logic pin_b_o,
  input  wire logic pin_b_oe,
  output logic      pin_a_wire,
  output logic      pin_b_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // pin A direction
  assign pin_a_wire = pin_a_oe ? pin_a_o : 1'b1;
  assign pin_b_wire = pin_b_oe ? pin_b_o : 1'b1;
endmodule // apsel_board_model

//--- tb/testbench.sv
// Purpose: Self-checking bench for the aux pin source selector
// Assumes: apsel_top and apsel_board_model compiled before this file
// Notes:   Inputs change by non-blocking assignment on the rising edge
`include "apsel_params.svh"
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module testbench
  import apsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, sys_rst, reg_wr, reg_rd, dir_a, dir_b;
  apsel_byte_t reg_addr, reg_wdata, reg_rdata_q, lvl;
  logic [27:0] s;
  logic        pin_a_o, pin_a_oe, pin_b_o, pin_b_oe, mute_o, pin_a_wire, pin_b_wire;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // ----------------------------------------
  // Design and board
  // ----------------------------------------
  // Source bit i feeds the pin B source whose select code is i; s[2] and s[6] are unconnected; s[0] and s[3] feed the pin A and mute DSP outputs
  apsel_top apsel_top_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .pin_a_dir_out(dir_a), .pin_b_dir_out(dir_b),
    .dsp_pin_a_out(s[0]), .dsp_pin_b_out(s[1]), .dsp_mute_out(s[3]),
    .auto_mute_l(s[4]), .auto_mute_r(s[5]), .serial_audio_out(s[7]),
    .analog_mute_l_n(s[8]), .analog_mute_r_n(s[9]), .pll_lock(s[10]), .cp_clk(s[11]),
    .short_l(s[12]), .short_r(s[13]), .soft_mute_input_uv_hi(s[14]), .soft_mute_input_uv_lo(s[15]),
    .pll_clk(s[16]), .osc_clk(s[17]), .imp_sense_l(s[18]), .imp_sense_r(s[19]),
    .undervoltage_protect(s[20]), .offset_cal_busy(s[21]), .clk_error(s[22]),
    .clk_changing(s[23]), .clk_missing(s[24]), .clk_halt(s[25]), .dsp_boot_done(s[26]),
    .cp_valid_n(s[27]), .aux_pin_a_o(pin_a_o), .aux_pin_a_oe(pin_a_oe),
    .aux_pin_b_o(pin_b_o), .aux_pin_b_oe(pin_b_oe), .mute_pin_o(mute_o)
  );

  apsel_board_model apsel_board_model_i (
    .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe),
    .pin_a_wire(pin_a_wire), .pin_b_wire(pin_b_wire)
  );

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Whole run needs about 1200 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input apsel_byte_t a, input apsel_byte_t d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input apsel_byte_t a, output apsel_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata_q;
  endtask

  // Covers selector, two synchroniser stages and the edge detector
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic exp_b(input apsel_sel_t c, input logic [27:0] v, input apsel_byte_t l);
    case (c)
      5'h00:   return 1'b0;
      5'h02:   return l[5];
      5'h03:   return v[4] & v[5];
      5'h06:   return v[22] | v[23] | v[24];
      default: return (c < 5'h1c) ? v[c] : 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    apsel_byte_t d;
    for (int a = 'h53; a <= 'h56; a++)
    begin
      rd(a[7:0], d);
      `CHK(d, `APSEL_RST_BYTE)
    end
    `CHK(pin_b_o, 1'b0)
  endtask

  task automatic test_regs;
    apsel_byte_t d;
    wr(`APSEL_OFS_PIN_B_SEL, 8'hff);
    rd(`APSEL_OFS_PIN_B_SEL, d);
    `CHK(d, 8'hff)
    @(posedge sys_clk);
    s <= 28'hfffffff;
    settle;
    `CHK(pin_b_o, 1'b0)
    wr(`APSEL_OFS_PIN_A_SEL, 8'he1);
    wr(`APSEL_OFS_SPARE, 8'h3c);
    rd(`APSEL_OFS_PIN_A_SEL, d);
    `CHK(d, 8'he1)
    rd(`APSEL_OFS_SPARE, d);
    `CHK(d, 8'h3c)
    wr(8'h60, 8'h5a);
    rd(8'h60, d);
    `CHK(d, 8'h00)
    wr(`APSEL_OFS_LEVELS, 8'ha5);
    rd(`APSEL_OFS_LEVELS, d);
    `CHK(d, 8'ha5)
  endtask

  task automatic test_codes;
    logic [27:0] p [3];
    lvl = 8'h20;
    wr(`APSEL_OFS_LEVELS, lvl);
    for (int c = 0; c < 32; c++)
    begin
      if (c == 16 || c == 17)
        continue;
      wr(`APSEL_OFS_PIN_B_SEL, c[7:0]);
      p[0] = 28'h1 << c;
      p[1] = ~p[0];
      p[2] = 28'h0800010;
      for (int k = 0; k < 3; k++)
      begin
        @(posedge sys_clk);
        s <= p[k];
        settle;
        `CHK(pin_b_o, exp_b(c[4:0], p[k], lvl))
      end
    end
    lvl = 8'hdf;
    wr(`APSEL_OFS_LEVELS, lvl);
    wr(`APSEL_OFS_PIN_B_SEL, 8'h02);
    settle;
    `CHK(pin_b_o, 1'b0)
  endtask

  task automatic test_dir;
    wr(`APSEL_OFS_PIN_B_SEL, 8'h00);
    wr(`APSEL_OFS_PIN_A_SEL, 8'h00);
    @(posedge sys_clk);
    dir_a <= 1'b0;
    dir_b <= 1'b0;
    settle;
    `CHK(pin_b_oe, 1'b0)
    `CHK(pin_b_wire, 1'b1)
    `CHK(pin_a_wire, 1'b1)
    @(posedge sys_clk);
    dir_a <= 1'b1;
    dir_b <= 1'b1;
    settle;
    `CHK(pin_b_wire, 1'b0)
    `CHK(pin_a_wire, 1'b0)
  endtask

  task automatic test_other_pins;
    apsel_byte_t t [3] = '{8'h08, 8'h10, 8'he7};
    wr(`APSEL_OFS_PIN_A_SEL, 8'h02);
    wr(`APSEL_OFS_SPARE, 8'h02);
    for (int k = 0; k < 3; k++)
    begin
      wr(`APSEL_OFS_LEVELS, t[k]);
      settle;
      `CHK(pin_a_wire, t[k][3])
      `CHK(mute_o, t[k][4])
    end
    wr(`APSEL_OFS_PIN_A_SEL, 8'h01);
    wr(`APSEL_OFS_SPARE, 8'h01);
    @(posedge sys_clk);
    s <= 28'h1;
    settle;
    `CHK(pin_a_o, 1'b1)
    `CHK(mute_o, 1'b0)
    @(posedge sys_clk);
    s <= 28'h8;
    settle;
    `CHK(pin_a_o, 1'b0)
    `CHK(mute_o, 1'b1)
  endtask

  // Second reset after the registers hold non-zero values
  task automatic test_mid_reset;
    apsel_byte_t d;
    wr(`APSEL_OFS_LEVELS, 8'hff);
    wr(`APSEL_OFS_PIN_B_SEL, 8'h02);
    settle;
    `CHK(pin_b_o, 1'b1)
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 'h53; a <= 'h56; a++)
    begin
      rd(a[7:0], d);
      `CHK(d, `APSEL_RST_BYTE)
    end
    `CHK(pin_b_o, 1'b0)
    `CHK(mute_o, 1'b0)
  endtask

  // Input period 8 cycles; 128 sampled cycles hold four output periods
  task automatic test_div_clk;
    int   edges;
    logic prev;
    for (int k = 0; k < 2; k++)
    begin
      wr(`APSEL_OFS_PIN_B_SEL, 8'h10 + k[7:0]);
      edges = 0;
      prev  = 1'b0;
      for (int t = 0; t < 160; t++)
      begin
        @(posedge sys_clk);
        s[16 + k] <= t[2];
        #1;
        if (t >= 32 && pin_b_o === 1'b1 && prev === 1'b0)
          edges++;
        prev = pin_b_o;
      end
      `CHK(edges, 4)
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    sys_rst   = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    dir_a     = 1'b1;
    dir_b     = 1'b1;
    s         = '0;
    lvl       = 8'h00;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    test_reset;
    test_regs;
    test_codes;
    test_dir;
    test_other_pins;
    test_mid_reset;
    test_div_clk;
    end_of_test;
  end
endmodule // testbench
